/* File: rtl/wdcs_top.sv */
// Watchdog control, stall, counter and status logic with its register port.
`timescale 1ns/10ps
`include "wdcs_cfg.svh"
module wdcs_top #(
    parameter int SLOW_DIV = `WDCS_SLOW_DIV
) (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    keep_resetn,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [`WDCS_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]             reg_wdata,
    output logic      [31:0]             reg_rdata,
    input  wire logic                    debug_active,
    input  wire logic                    week_timer_active,
    input  wire logic                    hib_timer0_active,
    input  wire logic                    hib_timer1_active,
    output logic                         expiry_interrupt,
    output logic                         expiry_reset_req
);

    wdcs_pkg::wdcs_state_s st;
    wdcs_pkg::wdcs_state_s next_st;

    logic stall;
    logic tick;
    logic dec;
    logic expire;
    logic wr_reload;
    logic wr_ctrl;
    logic wr_kick;
    logic wr_status;
    logic wr_mask;

    // Write strobes are decoded straight from the register port.
    assign wr_reload = reg_wr && (reg_addr == `WDCS_OFS_RELOAD);
    assign wr_ctrl   = reg_wr && (reg_addr == `WDCS_OFS_CTRL);
    assign wr_kick   = reg_wr && (reg_addr == `WDCS_OFS_KICK);
    assign wr_status = reg_wr && (reg_addr == `WDCS_OFS_STATUS);
    assign wr_mask   = reg_wr && (reg_addr == `WDCS_OFS_MASK);

    // Any enabled stall source freezes both dividers and the counter.
    assign stall = (st.dbg && debug_active)
                || (st.week && week_timer_active)
                || (st.hib && (hib_timer0_active || hib_timer1_active));

    // The slow tick stands in for the 32 kHz clock as a one-cycle enable.
    assign tick   = st.on && !stall
                 && (st.slow == 16'(SLOW_DIV - 1));
    assign dec    = tick && (st.pre == `WDCS_PRE_LAST);
    assign expire = dec && (st.count == '0);

    // Next-state logic; register writes are applied after counting so a
    // write in the same cycle as a decrement takes the written value.
    always_comb begin
        next_st           = st;
        next_st.irq_pulse = 1'b0;
        next_st.rst_pulse = 1'b0;
        // The prescalers only run while enabled and not stalled, so a stall
        // resumes exactly where it stopped.
        if (st.on && !stall) begin
            next_st.slow = tick ? 16'h0000 : st.slow + 16'h0001;
        end
        if (tick) begin
            next_st.pre = (st.pre == `WDCS_PRE_LAST) ? 6'h00
                                                     : st.pre + 6'h01;
        end
        if (dec) begin
            next_st.count = st.count - 16'h0001;
        end
        // Register writes.
        if (wr_ctrl) begin
            next_st.on   = reg_wdata[`WDCS_BIT_ON];
            next_st.hib  = reg_wdata[`WDCS_BIT_HIB];
            next_st.week = reg_wdata[`WDCS_BIT_WEEK];
            next_st.dbg  = reg_wdata[`WDCS_BIT_DBG];
            next_st.sel  = reg_wdata[`WDCS_BIT_SEL];
        end
        if (wr_mask) begin
            next_st.mask = reg_wdata[`WDCS_BIT_MASK];
        end
        if (wr_status && reg_wdata[`WDCS_BIT_FLAG]) begin
            next_st.flag = 1'b0;
        end
        if (wr_reload) begin
            next_st.reload = reg_wdata[`WDCS_CNT_W-1:0];
            next_st.count  = reg_wdata[`WDCS_CNT_W-1:0];
            next_st.slow   = 16'h0000;
            next_st.pre    = 6'h00;
        end else if (wr_kick && st.on) begin
            // A kick while disabled falls through here untouched.
            next_st.count = st.reload;
            next_st.slow  = 16'h0000;
            next_st.pre   = 6'h00;
        end
        // With select set, expiry wins over a same-cycle write of the select bit or a clear
        // of the flag, so an event is never lost.
        if (expire) begin
            if (!wr_reload) begin
                next_st.count = st.reload;
            end
            if (st.sel) begin
                next_st.irq_pulse = 1'b1;
                next_st.flag      = 1'b1;
                next_st.sel       = 1'b0;
            end else begin
                next_st.rst_pulse = 1'b1;
            end
        end
        // Read data is registered; unmapped and write-only offsets read 0.
        next_st.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `WDCS_OFS_RELOAD: next_st.rdata = {16'h0000, st.reload};
                `WDCS_OFS_CTRL: begin
                    next_st.rdata[`WDCS_BIT_ON]   = st.on;
                    next_st.rdata[`WDCS_BIT_HIB]  = st.hib;
                    next_st.rdata[`WDCS_BIT_WEEK] = st.week;
                    next_st.rdata[`WDCS_BIT_DBG]  = st.dbg;
                    next_st.rdata[`WDCS_BIT_SEL]  = st.sel;
                end
                `WDCS_OFS_KICK:   next_st.rdata = 32'h0000_0000;
                `WDCS_OFS_COUNT:  next_st.rdata = {16'h0000, st.count};
                `WDCS_OFS_STATUS: next_st.rdata[`WDCS_BIT_FLAG] = st.flag;
                `WDCS_OFS_MASK:   next_st.rdata[`WDCS_BIT_MASK] = st.mask;
                default:          next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // Two resets share one register process: the system reset leaves the
    // flag and mask alone so software can see why the subsystem restarted.
    always_ff @(posedge clk) begin
        st <= next_st;
        if (!resetn) begin
            st.reload    <= `WDCS_RST_RELOAD;
            st.count     <= `WDCS_RST_COUNT;
            st.sel       <= 1'b0;
            st.dbg       <= 1'b0;
            st.week      <= 1'b0;
            st.hib       <= 1'b0;
            st.on        <= 1'b0;
            st.slow      <= 16'h0000;
            st.pre       <= 6'h00;
            st.irq_pulse <= 1'b0;
            st.rst_pulse <= 1'b0;
            st.rdata     <= 32'h0000_0000;
        end
        if (!keep_resetn) begin
            st.flag <= 1'b0;
            st.mask <= 1'b0;
        end
    end

    // Outputs come straight from the state; the interrupt is a level.
    assign reg_rdata        = st.rdata;
    assign expiry_interrupt = st.flag && st.mask;
    assign expiry_reset_req = st.rst_pulse;

    // Checks on the counter, the registers and the expiry actions.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn || !keep_resetn);

    sequence s_irq_expiry;
        expire && st.sel;
    endsequence

    sequence s_irq_done;
        st.irq_pulse && st.flag && !st.sel;
    endsequence

    property p_irq_sel;
        s_irq_expiry |=> s_irq_done;
    endproperty
    a_irq_sel: assert property (p_irq_sel)
        else $error("Interrupt expiry did not set flag and clear select.");

    property p_rst_sel;
        st.rst_pulse |-> !$past(st.sel) && !st.irq_pulse;
    endproperty
    a_rst_sel: assert property (p_rst_sel)
        else $error("Reset request raised while select was set.");

    property p_stall_hold;
        (stall && !reg_wr) |=> $stable(st.count) && $stable(st.pre);
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("Counter moved during an enabled stall.");

    property p_week_hold;
        (st.week && week_timer_active && !reg_wr) |=> $stable(st.slow);
    endproperty
    a_week_hold: assert property (p_week_hold)
        else $error("Week timer stall did not hold the divider.");

    property p_hib_hold;
        (st.hib && (hib_timer0_active || hib_timer1_active) && !reg_wr)
            |=> $stable(st.count);
    endproperty
    a_hib_hold: assert property (p_hib_hold)
        else $error("Hibernation stall did not hold the counter.");

    property p_off_hold;
        (!st.on && !reg_wr) |=> $stable(st.count) && !st.irq_pulse
                                && !st.rst_pulse;
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("Disabled watchdog counted or expired.");

    property p_kick_load;
        (wr_kick && st.on && !expire) |=> st.count == $past(st.reload);
    endproperty
    a_kick_load: assert property (p_kick_load)
        else $error("Enabled kick did not reload the counter.");

    property p_kick_off;
        (wr_kick && !st.on) |=> $stable(st.count) && $stable(st.pre);
    endproperty
    a_kick_off: assert property (p_kick_off)
        else $error("Kick changed state while disabled.");

    property p_kick_read;
        (reg_rd && reg_addr == `WDCS_OFS_KICK) |=> reg_rdata == '0;
    endproperty
    a_kick_read: assert property (p_kick_read)
        else $error("Kick register read was not zero.");

    property p_w1c;
        (wr_status && reg_wdata[0] && !expire) |=> !st.flag;
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("Write of one did not clear the expiry flag.");

    property p_step;
        (dec && st.count != '0 && !wr_reload && !wr_kick)
            |=> st.count == $past(st.count) - 16'h0001 && st.pre == '0;
    endproperty
    a_step: assert property (p_step)
        else $error("Counter did not step down after 33 slow ticks.");

endmodule

/* File: pkg/wdcs_cfg.svh */
// Offsets, field positions, reset values and timing counts of the watchdog.
// Overview of operation
// - Expiry with select set interrupts, clears select.
// - Expiry with select clear requests subsystem reset.
// - Debug stall enable plus active debug holds counter.
// - Week stall enable plus active week timer holds.
// - Hibernation stall enable plus either timer holds.
// - Enable bit starts watchdog; resets to disabled.
// - Kick register is write strobe, reads zero.
// - Enabled kick copies reload value into counter.
// - Disabled kick is ignored entirely.
// - Count register shows counter, resets all ones.
// - Status bit zero flags expiry with select set, write-one clears.
// - Interrupt enable bit zero gates the interrupt.
// - Counter decrements once per 33 slow ticks.
// - After stall, counting resumes from held value.
// - Flag and mask survive the system reset.
// - Writing reload register also reloads the counter.
`ifndef WDCS_CFG_SVH
`define WDCS_CFG_SVH

`define WDCS_ADDR_W         8
`define WDCS_OFS_RELOAD     8'h00
`define WDCS_OFS_CTRL       8'h04
`define WDCS_OFS_KICK       8'h08
`define WDCS_OFS_COUNT      8'h0C
`define WDCS_OFS_STATUS     8'h10
`define WDCS_OFS_MASK       8'h14

`define WDCS_BIT_ON         0
`define WDCS_BIT_HIB        2
`define WDCS_BIT_WEEK       3
`define WDCS_BIT_DBG        4
`define WDCS_BIT_SEL        9
`define WDCS_BIT_FLAG       0
`define WDCS_BIT_MASK       0

`define WDCS_CNT_W          16
`define WDCS_RST_COUNT      16'hFFFF
`define WDCS_RST_RELOAD     16'hFFFF

`define WDCS_CLK_FREQ_HZ    200000000
`define WDCS_SLOW_FREQ_HZ   32768
`define WDCS_SLOW_DIV       (`WDCS_CLK_FREQ_HZ / `WDCS_SLOW_FREQ_HZ)
`define WDCS_PRE_TICKS      33
`define WDCS_PRE_LAST       6'h20

`endif

/* File: pkg/wdcs_pkg.sv */
// Types of the watchdog control and status block.
`include "wdcs_cfg.svh"
package wdcs_pkg;

    // Complete register and counter state of the watchdog.
    typedef struct packed {
        logic [`WDCS_CNT_W-1:0] reload;
        logic [`WDCS_CNT_W-1:0] count;
        logic                   sel;
        logic                   dbg;
        logic                   week;
        logic                   hib;
        logic                   on;
        logic                   flag;
        logic                   mask;
        logic [15:0]            slow;
        logic [5:0]             pre;
        logic                   irq_pulse;
        logic                   rst_pulse;
        logic [31:0]            rdata;
    } wdcs_state_s;

endpackage

/* File: sim/tb_wdcs_top.sv */
// Self-checking bench for the watchdog control and status block.
`timescale 1ns/10ps
`include "wdcs_cfg.svh"
module tb_wdcs_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        keep_resetn = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic        debug_active = 1'b0;
    logic        week_timer_active = 1'b0;
    logic        hib_timer0_active = 1'b0;
    logic        hib_timer1_active = 1'b0;
    logic        expiry_interrupt;
    logic        expiry_reset_req;
    logic        seen;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          stall_bit[4] = '{4, 3, 2, 2};

    // A short slow-tick divider keeps one count step at 132 clocks.
    wdcs_top #(.SLOW_DIV(4)) wdcs_top_i (
        .clk               (clk),
        .resetn            (resetn),
        .keep_resetn       (keep_resetn),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_rdata         (reg_rdata),
        .debug_active      (debug_active),
        .week_timer_active (week_timer_active),
        .hib_timer0_active (hib_timer0_active),
        .hib_timer1_active (hib_timer1_active),
        .expiry_interrupt  (expiry_interrupt),
        .expiry_reset_req  (expiry_reset_req)
    );

    // The clock toggles every half period of 2.5 ns.
    always #2.5 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hung wait is cut short here and reported as a mismatch.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data is registered, so it is taken one edge after the strobe.
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        samples_checked++;
        if (reg_rdata !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time,
                     reg_rdata, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Polls an output once per clock, after the edge has settled.
    task automatic wait_out(input logic rst_sel, input int lim);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge clk);
            #1;
            seen = rst_sel ? (expiry_reset_req === 1'b1)
                           : (expiry_interrupt === 1'b1);
        end
    endtask

    // Main sequence; both resets are held for three edges at the start.
    initial begin
        cyc(3);
        resetn <= 1'b1;
        keep_resetn <= 1'b1;
        chk_reg(`WDCS_OFS_COUNT, 32'h0000FFFF);
        chk_reg(`WDCS_OFS_RELOAD, 32'h0000FFFF);
        chk_reg(`WDCS_OFS_CTRL, 32'h00000000);
        chk_reg(`WDCS_OFS_STATUS, 32'h00000000);
        chk_reg(`WDCS_OFS_MASK, 32'h00000000);
        chk_reg(`WDCS_OFS_KICK, 32'h00000000);
        chk_reg(8'h18, 32'h00000000);
        wr(`WDCS_OFS_RELOAD, 32'h5);
        chk_reg(`WDCS_OFS_COUNT, 32'h5);
        wr(`WDCS_OFS_CTRL, 32'h1);
        wr(`WDCS_OFS_KICK, 32'hA5);
        cyc(120);
        chk_reg(`WDCS_OFS_COUNT, 32'h5);
        cyc(15);
        chk_reg(`WDCS_OFS_COUNT, 32'h4);
        wr(`WDCS_OFS_CTRL, 32'h0);
        cyc(300);
        chk_reg(`WDCS_OFS_COUNT, 32'h4);
        wr(`WDCS_OFS_KICK, 32'hFF);
        chk_reg(`WDCS_OFS_COUNT, 32'h4);
        wr(`WDCS_OFS_CTRL, 32'h1);
        wr(`WDCS_OFS_KICK, 32'h01);
        chk_reg(`WDCS_OFS_COUNT, 32'h5);
        // Each stall source holds the count; release resumes from there.
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            debug_active <= (i == 0);
            week_timer_active <= (i == 1);
            hib_timer0_active <= (i == 2);
            hib_timer1_active <= (i == 3);
            wr(`WDCS_OFS_CTRL, 32'h1 | (32'h1 << stall_bit[i]));
            wr(`WDCS_OFS_RELOAD, 32'h3);
            cyc(300);
            chk_reg(`WDCS_OFS_COUNT, 32'h3);
            @(posedge clk);
            debug_active <= 1'b0;
            week_timer_active <= 1'b0;
            hib_timer0_active <= 1'b0;
            hib_timer1_active <= 1'b0;
            cyc(140);
            chk_reg(`WDCS_OFS_COUNT, 32'h2);
        end
        // With its enable bit clear, an active week timer changes nothing.
        @(posedge clk);
        week_timer_active <= 1'b1;
        wr(`WDCS_OFS_CTRL, 32'h1);
        wr(`WDCS_OFS_RELOAD, 32'h3);
        cyc(140);
        chk_reg(`WDCS_OFS_COUNT, 32'h2);
        @(posedge clk);
        week_timer_active <= 1'b0;
        wr(`WDCS_OFS_MASK, 32'h1);
        wr(`WDCS_OFS_RELOAD, 32'h1);
        wr(`WDCS_OFS_CTRL, 32'h201);
        wait_out(1'b0, 400);
        chk_bit(seen, 1'b1);
        chk_bit(expiry_reset_req, 1'b0);
        chk_reg(`WDCS_OFS_CTRL, 32'h1);
        wr(`WDCS_OFS_CTRL, 32'h0);
        chk_reg(`WDCS_OFS_COUNT, 32'h1);
        wr(`WDCS_OFS_STATUS, 32'h0);
        chk_reg(`WDCS_OFS_STATUS, 32'h1);
        wr(`WDCS_OFS_STATUS, 32'h1);
        chk_reg(`WDCS_OFS_STATUS, 32'h0);
        chk_bit(expiry_interrupt, 1'b0);
        // A masked expiry still sets the flag but raises no interrupt.
        wr(`WDCS_OFS_MASK, 32'h0);
        wr(`WDCS_OFS_RELOAD, 32'h1);
        wr(`WDCS_OFS_CTRL, 32'h201);
        cyc(320);
        wr(`WDCS_OFS_CTRL, 32'h0);
        chk_reg(`WDCS_OFS_STATUS, 32'h1);
        chk_bit(expiry_interrupt, 1'b0);
        wr(`WDCS_OFS_MASK, 32'h1);
        cyc(1);
        chk_bit(expiry_interrupt, 1'b1);
        // Expiry with select clear asks for a reset, one cycle long.
        wr(`WDCS_OFS_RELOAD, 32'h1);
        wr(`WDCS_OFS_CTRL, 32'h1);
        wait_out(1'b1, 400);
        chk_bit(seen, 1'b1);
        @(posedge clk);
        #1;
        chk_bit(expiry_reset_req, 1'b0);
        chk_reg(`WDCS_OFS_COUNT, 32'h1);
        @(posedge clk);
        resetn <= 1'b0;
        cyc(3);
        resetn <= 1'b1;
        chk_reg(`WDCS_OFS_STATUS, 32'h1);
        chk_reg(`WDCS_OFS_MASK, 32'h1);
        chk_reg(`WDCS_OFS_CTRL, 32'h0);
        chk_reg(`WDCS_OFS_COUNT, 32'h0000FFFF);
        tally_and_finish();
    end
endmodule
